// file: common/fcdo_pkg.sv
// Purpose: Constants and types for the flash clock divider and option block
// Assumes: APB slave with 32-bit data, 100 MHz bus clock
// Notes: Register values sit in the low byte of each word
package fcdo_pkg;
    localparam logic [11:0] ADDR_CLK_DIV = 12'h000;
    localparam logic [11:0] ADDR_OPTION = 12'h004;
    localparam logic [11:0] ADDR_KEY_CTRL = 12'h008;
    localparam logic [11:0] ADDR_KEY_LO = 12'h00c;
    localparam logic [11:0] ADDR_KEY_HI = 12'h010;
    localparam logic [11:0] ADDR_STATUS = 12'h014;
    localparam logic [11:0] ADDR_CMD = 12'h018;
    localparam int LOADED_BIT = 7;
    localparam int PRESCALE_BIT = 6;
    localparam int DIV_MSB = 5;
    localparam int BACKDOOR_EN_BIT = 7;
    localparam int NORED_BIT = 6;
    localparam int SEC_MSB = 1;
    localparam logic [1:0] SEC_UNSECURED = 2'h2;
    localparam logic [7:0] CLK_DIV_RESET = 8'h00;
    localparam logic [7:0] OPTION_USED_MASK = 8'hc3;
    localparam logic [2:0] PRESCALE_TOP = 3'h7;
    localparam logic [3:0] KEY_BYTES = 4'h8;
    localparam logic [7:0] PULSES_PER_OP = 8'h04;
    typedef struct packed {
        logic prescale_by_eight;
        logic [5:0] divisor_field;
    } fcdo_div_t;
    typedef struct packed {
        logic backdoor_enable;
        logic vector_redirect_disable;
        logic [1:0] security_code;
    } fcdo_opt_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b11
    } fcdo_state_t;
endpackage

// file: rtl/fcdo_top.sv
// Purpose: Flash clock divider, option copy, security and operation gate
// Assumes: APB slave, one clock mclk, synchronous active-low reset
// Notes: Key comparison uses the stored key given as an input
`timescale 1ns/1ps
// Summary of operation
// - Bit 7 set by first write
// - Bits 6:0 readable, written once
// - Erase and program need loaded flag
// - Prescale bit divides bus clock by eight
// - Divider ratio is 2 x (divisor plus one)
// - Operations use whole flash clock pulses
// - Option byte copied during reset
// - Option bits 5:2 zero, writes ignored
// - Backdoor disabled when enable bit zero
// - Debug key writes never unlock
// - Matching eight-byte key unlocks until reset
// - Option bit 6 disables vector redirection
// - Only code 1:0 means unsecured
// - Secure blocks unsecured memory access
// - Key match or blank forces 1:0
// - Early operation ignored, access error set
module fcdo_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Nonvolatile contents
    input wire logic [7:0] nonvolatile_option_byte,
    input wire logic [63:0] stored_backdoor_key,
    input wire logic blank_check_pass,
    // Memory access request from unsecured source
    input wire logic unsecured_access_req,
    // Flash side
    output logic internal_flash_clock,
    output logic program_erase_enable,
    output logic timing_pulse,
    output logic op_busy,
    output logic access_granted,
    output logic vector_redirect_disable
);
    logic loaded_r, loaded_nxt;
    fcdo_pkg::fcdo_div_t div_r, div_nxt;
    fcdo_pkg::fcdo_opt_t opt_r, opt_nxt;
    logic [2:0] pre_cnt_r, pre_cnt_nxt;
    logic [5:0] div_cnt_r, div_cnt_nxt;
    logic internal_flash_clock_r, internal_flash_clock_nxt, pulse_r, pulse_nxt;
    logic keyacc_r, keyacc_nxt;
    logic [63:0] key_r, key_nxt;
    logic [3:0] key_cnt_r, key_cnt_nxt;
    logic key_bad_r, key_bad_nxt;
    logic unlock_r, unlock_nxt;
    logic accerr_r, accerr_nxt;
    fcdo_pkg::fcdo_state_t st_r, st_nxt;
    logic [7:0] op_cnt_r, op_cnt_nxt;
    logic [31:0] prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic grant_r, grant_nxt, pe_r, redir_r, busy_r;
    logic wr, rd, secure_src, pre_tick, div_tick;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
        return a == b;
    endfunction

    assign wr = psel && penable && pwrite && !pready_r;
    assign rd = psel && penable && !pwrite && !pready_r;
    // Nonprivileged protection bit marks debug origin
    assign secure_src = pprot[0];
    assign pre_tick = !div_r.prescale_by_eight ||
                      pre_cnt_r == fcdo_pkg::PRESCALE_TOP;
    assign div_tick = pre_tick && div_cnt_r == div_r.divisor_field;

    always_comb begin
        loaded_nxt = loaded_r;
        div_nxt = div_r;
        opt_nxt = opt_r;
        pre_cnt_nxt = div_r.prescale_by_eight ? pre_cnt_r + 3'h1 : 3'h0;
        div_cnt_nxt = div_cnt_r;
        internal_flash_clock_nxt = internal_flash_clock_r;
        pulse_nxt = 1'b0;
        keyacc_nxt = keyacc_r;
        key_nxt = key_r;
        key_cnt_nxt = key_cnt_r;
        key_bad_nxt = key_bad_r;
        unlock_nxt = unlock_r;
        accerr_nxt = accerr_r;
        st_nxt = st_r;
        op_cnt_nxt = op_cnt_r;
        prdata_nxt = 32'h0;
        pready_nxt = psel && penable && !pready_r;
        pslverr_nxt = 1'b0;
        grant_nxt = !unsecured_access_req ||
                    opt_r.security_code == fcdo_pkg::SEC_UNSECURED;
        if (pre_tick) begin
            if (div_tick) begin
                div_cnt_nxt = 6'h0;
                internal_flash_clock_nxt = !internal_flash_clock_r;
                pulse_nxt = internal_flash_clock_r;
            end else begin
                div_cnt_nxt = div_cnt_r + 6'h1;
            end
        end
        if (wr && hit(paddr, fcdo_pkg::ADDR_CLK_DIV)) begin
            loaded_nxt = 1'b1;
            if (!loaded_r) begin
                div_nxt = pwdata[fcdo_pkg::PRESCALE_BIT:0];
            end
        end
        if (wr && hit(paddr, fcdo_pkg::ADDR_KEY_CTRL)) begin
            keyacc_nxt = pwdata[0];
            if (pwdata[0]) begin
                key_cnt_nxt = 4'h0;
                key_bad_nxt = 1'b0;
            end else if (keyacc_r && opt_r.backdoor_enable && !key_bad_r &&
                         key_cnt_r == fcdo_pkg::KEY_BYTES &&
                         key_r == stored_backdoor_key) begin
                unlock_nxt = 1'b1;
            end
        end
        if (wr && keyacc_r && hit(paddr, fcdo_pkg::ADDR_KEY_LO)) begin
            if (!secure_src || key_cnt_r == fcdo_pkg::KEY_BYTES) begin
                key_bad_nxt = 1'b1;
            end else begin
                key_nxt = {pwdata[7:0], key_r[63:8]};
                key_cnt_nxt = key_cnt_r + 4'h1;
            end
        end
        if (unlock_r || blank_check_pass) begin
            opt_nxt.security_code = fcdo_pkg::SEC_UNSECURED;
        end
        if (wr && hit(paddr, fcdo_pkg::ADDR_STATUS) && pwdata[0]) begin
            accerr_nxt = 1'b0;
        end
        if (wr && hit(paddr, fcdo_pkg::ADDR_CMD)) begin
            if (!loaded_r || st_r != fcdo_pkg::ST_IDLE) begin
                accerr_nxt = 1'b1;
            end else begin
                st_nxt = fcdo_pkg::ST_BUSY;
                op_cnt_nxt = fcdo_pkg::PULSES_PER_OP;
            end
        end
        unique case (st_r)
            fcdo_pkg::ST_IDLE: begin
            end
            fcdo_pkg::ST_BUSY: begin
                if (pulse_r) begin
                    op_cnt_nxt = op_cnt_r - 8'h1;
                    if (op_cnt_r == 8'h1) begin
                        st_nxt = fcdo_pkg::ST_DONE;
                    end
                end
            end
            fcdo_pkg::ST_DONE: st_nxt = fcdo_pkg::ST_IDLE;
            default: st_nxt = fcdo_pkg::ST_IDLE;
        endcase
        if (rd) begin
            unique case (1'b1)
                hit(paddr, fcdo_pkg::ADDR_CLK_DIV):
                    prdata_nxt[7:0] = {loaded_r, div_r};
                hit(paddr, fcdo_pkg::ADDR_OPTION):
                    prdata_nxt[7:0] = {opt_r.backdoor_enable,
                        opt_r.vector_redirect_disable, 4'h0,
                        opt_r.security_code};
                hit(paddr, fcdo_pkg::ADDR_KEY_CTRL):
                    prdata_nxt[0] = keyacc_r;
                hit(paddr, fcdo_pkg::ADDR_STATUS):
                    prdata_nxt[2:0] = {unlock_r, op_busy, accerr_r};
                hit(paddr, fcdo_pkg::ADDR_CMD): prdata_nxt = 32'h0;
                default: pslverr_nxt = 1'b1;
            endcase
        end
        if (wr && !(hit(paddr, fcdo_pkg::ADDR_CLK_DIV) ||
                    hit(paddr, fcdo_pkg::ADDR_OPTION) ||
                    hit(paddr, fcdo_pkg::ADDR_KEY_CTRL) ||
                    hit(paddr, fcdo_pkg::ADDR_KEY_LO) ||
                    hit(paddr, fcdo_pkg::ADDR_STATUS) ||
                    hit(paddr, fcdo_pkg::ADDR_CMD))) begin
            pslverr_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            loaded_r <= 1'b0;
            div_r <= fcdo_pkg::CLK_DIV_RESET[fcdo_pkg::PRESCALE_BIT:0];
            pre_cnt_r <= 3'h0;
            div_cnt_r <= 6'h0;
            internal_flash_clock_r <= 1'b0;
            pulse_r <= 1'b0;
            keyacc_r <= 1'b0;
            key_r <= 64'h0;
            key_cnt_r <= 4'h0;
            key_bad_r <= 1'b0;
            unlock_r <= 1'b0;
            accerr_r <= 1'b0;
            st_r <= fcdo_pkg::ST_IDLE;
            op_cnt_r <= 8'h0;
            prdata <= 32'h0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            grant_r <= 1'b0;
            pe_r <= 1'b0;
            redir_r <= 1'b0;
            busy_r <= 1'b0;
            // Option copy taken while reset is held; clocked, not async
            opt_r <= {nonvolatile_option_byte[fcdo_pkg::BACKDOOR_EN_BIT],
                      nonvolatile_option_byte[fcdo_pkg::NORED_BIT],
                      nonvolatile_option_byte[fcdo_pkg::SEC_MSB:0]};
        end else begin
            loaded_r <= loaded_nxt;
            div_r <= div_nxt;
            opt_r <= opt_nxt;
            pre_cnt_r <= pre_cnt_nxt;
            div_cnt_r <= div_cnt_nxt;
            internal_flash_clock_r <= internal_flash_clock_nxt;
            pulse_r <= pulse_nxt;
            keyacc_r <= keyacc_nxt;
            key_r <= key_nxt;
            key_cnt_r <= key_cnt_nxt;
            key_bad_r <= key_bad_nxt;
            unlock_r <= unlock_nxt;
            accerr_r <= accerr_nxt;
            st_r <= st_nxt;
            op_cnt_r <= op_cnt_nxt;
            prdata <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            grant_r <= grant_nxt;
            pe_r <= loaded_nxt;
            redir_r <= opt_nxt.vector_redirect_disable;
            busy_r <= st_nxt == fcdo_pkg::ST_BUSY;
        end
    end

    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign internal_flash_clock = internal_flash_clock_r;
    assign timing_pulse = pulse_r;
    assign op_busy = busy_r;
    assign access_granted = grant_r;
    assign program_erase_enable = pe_r;
    assign vector_redirect_disable = redir_r;
endmodule

// file: tb/fcdo_top_chk.sv
// Purpose: Port assertions for fcdo_top
// Assumes: APB slave with one wait state, sync active-low reset
// Notes: Bound into every fcdo_top instance
`timescale 1ns/1ps
module fcdo_top_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Flash side
    input wire logic program_erase_enable,
    input wire logic timing_pulse,
    input wire logic op_busy,
    input wire logic vector_redirect_disable
);
    wire div_wr = psel && penable && pwrite && paddr == 12'h000;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_take;
        psel && penable && !pready;
    endsequence
    sequence s_busy_start;
        $rose(op_busy);
    endsequence
    AST_PREADY_WAIT:
        assert property (s_take |=> pready) else $error("no answer");
    AST_PREADY_ONE:
        assert property (pready |=> !pready) else $error("long pready");
    AST_SLVERR_WITH:
        assert property (pslverr |-> pready) else $error("stray pslverr");
    AST_LOAD_CAUSE:
        assert property ($rose(program_erase_enable) |->
            $past(div_wr) || $past(div_wr, 2)) else $error("loaded early");
    AST_LOAD_HOLD:
        assert property (program_erase_enable |=> program_erase_enable)
            else $error("loaded flag lost");
    AST_REDIR_HOLD:
        assert property (rst_b && $past(rst_b) && $past(rst_b, 2) |->
            $stable(vector_redirect_disable)) else $error("option moved");
    AST_BUSY_LOADED:
        assert property (op_busy |-> program_erase_enable)
            else $error("op without divider");
    AST_BUSY_ENDS:
        assert property (s_busy_start |-> ##[1:1000] !op_busy)
            else $error("op hangs");
    AST_PULSE_ONE:
        assert property (timing_pulse |=> !timing_pulse)
            else $error("long pulse");
endmodule
bind fcdo_top fcdo_top_chk fcdo_top_chk_inst (.mclk, .rst_b, .psel,
    .penable, .pwrite, .paddr, .pready, .pslverr, .program_erase_enable,
    .timing_pulse, .op_busy, .vector_redirect_disable);

// file: tb/fcdo_top_tb_top.sv
// Purpose: Self-checking bench for fcdo_top
// Assumes: APB with one wait state, 100 MHz mclk
// Notes: Key and option byte are driven as levels
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end
module fcdo_top_tb_top;
    logic mclk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pprot;
    logic [7:0] nv;
    logic blank_check_pass, unsecured_access_req, internal_flash_clock;
    logic program_erase_enable, timing_pulse, op_busy, access_granted;
    logic vector_redirect_disable, e;
    logic [63:0] key = 64'h0123456789abcdef;
    int failures = 0, n_checks = 0, cnt;
    fcdo_top fcdo_top_inst (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pprot, .prdata, .pready, .pslverr,
        .nonvolatile_option_byte(nv), .stored_backdoor_key(key),
        .blank_check_pass, .unsecured_access_req, .internal_flash_clock,
        .program_erase_enable, .timing_pulse, .op_busy, .access_granted,
        .vector_redirect_disable);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int i;
        i = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i >= 50) begin
            failures++;
            final_report();
        end
        @(posedge mclk);
    endtask
    task automatic rst(input logic [7:0] o);
        rst_b <= 1'b0;
        nv <= o;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
    endtask
    task automatic unlock(input logic [3:0] p);
        pprot <= p;
        apb(1'b1, 12'h008, 32'h1);
        for (int i = 0; i < 8; i++)
            apb(1'b1, 12'h00c, {24'h0, key[8*i+:8]});
        apb(1'b1, 12'h008, 32'h0);
    endtask
    task automatic meas(input int e);
        int i;
        i = 0;
        while (timing_pulse !== 1'b1 && i < 999) begin
            @(posedge mclk);
            i++;
        end
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (timing_pulse !== 1'b1 && i < 999);
        `CHK(i, e)
        `CHK(internal_flash_clock, 1'b0)
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        failures++;
        final_report();
    end
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, pprot, nv} = '0;
        blank_check_pass = 1'b0;
        unsecured_access_req = 1'b1;
        @(posedge mclk);
        for (int c = 0; c < 4; c++) begin
            rst({1'b1, c[0], 4'hf, c[1:0]});
            apb(1'b0, 12'h004, 32'h0);
            `CHK(r, {24'h0, nv & 8'hc3})
            `CHK(vector_redirect_disable, c[0])
            `CHK(access_granted, c == 2)
        end
        apb(1'b1, 12'h004, 32'hff);
        apb(1'b0, 12'h004, 32'h0);
        `CHK(r, 32'hc3)
        `CHK(e, 1'b0)
        apb(1'b0, 12'h01c, 32'h0);
        `CHK(e, 1'b1)
        apb(1'b0, 12'h000, 32'h0);
        `CHK(r, 32'h0)
        `CHK(program_erase_enable, 1'b0)
        apb(1'b1, 12'h018, 32'h1);
        apb(1'b0, 12'h014, 32'h0);
        `CHK(r[1:0], 2'b01)
        apb(1'b1, 12'h014, 32'h1);
        unlock(4'h0);
        apb(1'b0, 12'h004, 32'h0);
        `CHK(r, 32'hc3)
        unlock(4'h1);
        apb(1'b0, 12'h004, 32'h0);
        `CHK(r, 32'hc2)
        `CHK(access_granted, 1'b1)
        apb(1'b1, 12'h000, 32'h41);
        apb(1'b1, 12'h000, 32'h05);
        apb(1'b0, 12'h000, 32'h0);
        `CHK(r, 32'hc1)
        `CHK(program_erase_enable, 1'b1)
        meas(32);
        apb(1'b1, 12'h018, 32'h1);
        cnt = 0;
        repeat (300) begin
            @(posedge mclk);
            cnt += (timing_pulse === 1'b1 && op_busy === 1'b1);
        end
        `CHK(cnt, 4)
        rst(8'h43);
        unlock(4'h1);
        apb(1'b0, 12'h004, 32'h0);
        `CHK(r, 32'h43)
        apb(1'b0, 12'h000, 32'h0);
        `CHK(r, 32'h0)
        blank_check_pass <= 1'b1;
        @(posedge mclk);
        blank_check_pass <= 1'b0;
        apb(1'b0, 12'h004, 32'h0);
        `CHK(r, 32'h42)
        apb(1'b1, 12'h000, 32'h02);
        meas(6);
        final_report();
    end
endmodule
